// >>> rtl/swd_params.svh
// Behaviour
// (RULE1) Special single-chip reset leaves debug firmware enabled and background mode active.
// (RULE2) Background mode maps seven debug registers at FF00 to FF06.
// (RULE3) Host starts every bit time with a falling edge on the line.
// (RULE4) Fields go most significant bit first, sixteen bus cycles per bit.
// (RULE5) 512 cycles without a host falling edge clears the command register.
// (RULE6) Received bit is sampled ten cycles after the perceived bit start.
// (RULE7) Device never drives the line while host sends bits.
// (RULE8) Device drives a high speed-up pulse seven cycles after start.
// (RULE9) Host samples device bits about ten cycles after its falling edge.
// (RULE10) A sent zero is held low thirteen cycles, then driven briefly high.
// (RULE11) Hardware commands use free bus cycles, stealing one after 128 cycles.
// (RULE12) Opcode 90 requests background entry, effective only with firmware enabled.
// (RULE13) Read opcodes E4, EC, E0, E8 take an address and return 16 bits.
// (RULE14) Write opcodes C4, CC, C0, C8 take an address then 16 data bits.
// (RULE15) Byte data: odd address low byte, even address high byte; words aligned.
// (RULE16) Debug resources are mapped in only for debug-resource access cycles; the code also maps them throughout background mode.
// (RULE17) Firmware commands accepted only in background mode; firmware ROM from FF20.
// (RULE18) Register opcodes 62-67 read, 42-47 write, 16 bits; next variants add two.
// (RULE19) Opcodes 08 resume, 10 single step, 18 enable tagging and resume.
// (RULE20) Commands open with an 8-bit opcode; every read returns 16 bits.
// (RULE21) Host allows 150 cycles for a non-intrusive command to finish.
// (RULE22) Host waits about 32 cycles before firmware read data portion.
// (RULE23) Background request without firmware enabled leaves the CPU running.
// (RULE24) Host waits about 64 cycles after resume or single step.
// (RULE25) Line input is synchronised before falling edges are detected.
`ifndef SWD_PARAMS_SVH
`define SWD_PARAMS_SVH
`define SWD_CLK_MHZ        10
`define SWD_BIT_CYC        16
`define SWD_TIMEOUT_CYC    512
`define SWD_SAMPLE_CYC     10
`define SWD_SPEEDUP_CYC    7
`define SWD_ZERO_LOW_CYC   13
`define SWD_STEAL_CYC      128
`define SWD_OP_BACKGROUND  8'h90
`define SWD_OP_RD_DBG_BYTE 8'hE4
`define SWD_OP_RD_DBG_WORD 8'hEC
`define SWD_OP_RD_BYTE     8'hE0
`define SWD_OP_RD_WORD     8'hE8
`define SWD_OP_WR_DBG_BYTE 8'hC4
`define SWD_OP_WR_DBG_WORD 8'hCC
`define SWD_OP_WR_BYTE     8'hC0
`define SWD_OP_WR_WORD     8'hC8
`define SWD_OP_GO          8'h08
`define SWD_OP_TRACE       8'h10
`define SWD_OP_TAG_AND_RESUME_CMD       8'h18
`define SWD_DBG_REG_LO     16'hFF00
`define SWD_DBG_REG_HI     16'hFF06
`define SWD_DBG_ROM_LO     16'hFF20
`endif

// >>> rtl/swd_pkg.sv
package swd_pkg;
	typedef enum logic [1:0] {
		SWD_RX_OPC,
		SWD_RX_ADDR,
		SWD_RX_DATA,
		SWD_TX_DATA
	} swd_phase_e;

	typedef struct packed {
		logic        req;
		logic        write;
		logic        dbg_map;
		logic        word;
		logic [15:0] addr;
		logic [15:0] wdata;
	} swd_mem_req_s;

	typedef struct packed {
		logic       req;
		logic       write;
		logic [2:0] reg_sel;
		logic [15:0] wdata;
	} swd_fw_req_s;
endpackage : swd_pkg

// >>> rtl/swd_port.sv
`timescale 1ns/1ps
`include "swd_params.svh"
module swd_port #(
	parameter int BIT_CYC   = `SWD_BIT_CYC,
	parameter int STEAL_CYC = `SWD_STEAL_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  special_single_chip,
	input  wire logic                  debug_wire_pin_i,
	output logic                       debug_wire_pin_o,
	output logic                       debug_wire_pin_oe,
	input  wire logic                  cpu_bus_free,
	output logic                       cpu_freeze,
	output swd_pkg::swd_mem_req_s      mem_req,
	input  wire logic                  mem_done,
	input  wire logic [15:0]           mem_rdata,
	output logic                       dbg_map_en,
	output logic                       dbg_rom_map_en,
	output logic                       background_debug_mode,
	input  wire logic                  debug_firmware_enable,
	input  wire logic                  bdm_exit,
	output logic                       bg_enter_req,
	output logic                       bg_request_dropped,
	output swd_pkg::swd_fw_req_s       fw_req,
	output logic [7:0]                 fw_cmd,
	input  wire logic                  fw_rdata_valid,
	input  wire logic [15:0]           fw_rdata,
	output logic                       resume_req,
	output logic                       single_step_cmd,
	output logic                       tag_and_resume_cmd,
	output logic                       timeout
);
	localparam int SPEEDUP_END = `SWD_SPEEDUP_CYC + 1;
	localparam int ZERO_END    = `SWD_ZERO_LOW_CYC + 1;

	logic              sync1;
	logic              sync2;
	logic              line_q;
	logic              in_bit;
	logic              bit_is_tx;
	logic              boot_pending;
	logic [4:0]        bit_cnt;
	logic [9:0]        idle_cnt;
	logic              fall;
	logic [4:0]        nbits;
	logic [15:0]       shreg;
	logic [7:0]        cmd;
	logic [15:0]       addr;
	logic              busy;
	logic [7:0]        wait_cnt;
	logic              tx_ready;
	swd_pkg::swd_phase_e phase;

	function automatic logic is_hw_mem(input logic [7:0] op);
		is_hw_mem = (op[7:6] == 2'b11) && (op[2:0] == 3'b000 || op[2:0] == 3'b100)
			&& (op[4] == 1'b0);
	endfunction : is_hw_mem

	function automatic logic is_fw_rw(input logic [7:0] op);
		is_fw_rw = ((op[7:4] == 4'h6) || (op[7:4] == 4'h4)) && (op[3:0] >= 4'h2)
			&& (op[3:0] <= 4'h7);
	endfunction : is_fw_rw

	// Line synchroniser and edge detect
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync1  <= 1'b1;
			sync2  <= 1'b1;
			line_q <= 1'b1;
		end else begin
			sync1  <= debug_wire_pin_i;
			sync2  <= sync1; // [RULE25]
			line_q <= sync2;
		end
	end
	assign fall = line_q & ~sync2; // [RULE3]

	// Bit timer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_bit    <= 1'b0;
			bit_cnt   <= 5'h00;
			bit_is_tx <= 1'b0;
		end else if (fall && !in_bit) begin
			in_bit    <= 1'b1;
			bit_cnt   <= 5'h01;
			bit_is_tx <= phase == swd_pkg::SWD_TX_DATA;
		end else if (in_bit) begin
			if (bit_cnt == 5'(BIT_CYC - 1)) begin // [RULE4]
				in_bit <= 1'b0;
			end
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// Inactivity time-out
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			idle_cnt <= 10'h000;
			timeout  <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (fall) begin
				idle_cnt <= 10'h000;
			end else if (phase != swd_pkg::SWD_RX_OPC || nbits != 5'h00) begin
				if (idle_cnt == 10'(`SWD_TIMEOUT_CYC - 1)) begin
					timeout  <= 1'b1; // [RULE5]
					idle_cnt <= 10'h000;
				end else begin
					idle_cnt <= idle_cnt + 10'h001;
				end
			end else begin
				idle_cnt <= 10'h000;
			end
		end
	end

	// Transmit drive: low for zero, then speed-up high pulse
	always_comb begin
		debug_wire_pin_oe = 1'b0;
		debug_wire_pin_o  = 1'b0;
		// Tail of a host bit that ends after the load stays undriven
		if (in_bit && bit_is_tx && phase == swd_pkg::SWD_TX_DATA) begin // [RULE7]
			if (!shreg[15] && bit_cnt < 5'(ZERO_END)) begin
				debug_wire_pin_oe = 1'b1; // [RULE10]
			end else if (!shreg[15] && bit_cnt == 5'(ZERO_END)) begin
				debug_wire_pin_oe = 1'b1;
				debug_wire_pin_o  = 1'b1;
			end else if (shreg[15] && bit_cnt == 5'(SPEEDUP_END)) begin
				debug_wire_pin_oe = 1'b1; // [RULE8]
				debug_wire_pin_o  = 1'b1;
			end
		end
	end

	// Serial shifter and command sequencing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase <= swd_pkg::SWD_RX_OPC;
			nbits <= 5'h00;
			shreg <= 16'h0000;
			cmd   <= 8'h00;
			addr  <= 16'h0000;
		end else if (timeout) begin
			phase <= swd_pkg::SWD_RX_OPC; // [RULE5]
			nbits <= 5'h00;
			cmd   <= 8'h00;
		end else if (tx_ready) begin
			phase <= swd_pkg::SWD_TX_DATA;
			nbits <= 5'h00;
			shreg <= fw_rdata_valid ? fw_rdata : mem_rdata; // [RULE20]
		end else if (in_bit && bit_cnt == 5'(`SWD_SAMPLE_CYC + 1)
				&& phase != swd_pkg::SWD_TX_DATA) begin
			shreg <= {shreg[14:0], sync2}; // [RULE6] [RULE4]
			nbits <= nbits + 5'h01;
			if (phase == swd_pkg::SWD_RX_OPC && nbits == 5'd7) begin
				cmd   <= {shreg[6:0], sync2}; // [RULE20]
				nbits <= 5'h00;
				if (is_hw_mem({shreg[6:0], sync2})) begin
					phase <= swd_pkg::SWD_RX_ADDR; // [RULE13] [RULE14]
				end else if (is_fw_rw({shreg[6:0], sync2}) && background_debug_mode
						&& !shreg[4]) begin
					phase <= swd_pkg::SWD_RX_DATA; // [RULE18]
				end
			end else if (nbits == 5'd15) begin
				nbits <= 5'h00;
				if (phase == swd_pkg::SWD_RX_ADDR) begin
					addr  <= {shreg[14:0], sync2};
					phase <= cmd[5] ? swd_pkg::SWD_RX_OPC : swd_pkg::SWD_RX_DATA;
				end else begin
					phase <= swd_pkg::SWD_RX_OPC;
				end
			end
		end else if (in_bit && bit_cnt == 5'(BIT_CYC - 1)
				&& bit_is_tx && phase == swd_pkg::SWD_TX_DATA) begin
			shreg <= {shreg[14:0], 1'b0};
			nbits <= nbits + 5'h01;
			if (nbits == 5'd15) begin
				phase <= swd_pkg::SWD_RX_OPC;
				nbits <= 5'h00;
			end
		end
	end

	// Strobes decoded from a completed field
	logic rx_done;
	assign rx_done = in_bit && bit_cnt == 5'(`SWD_SAMPLE_CYC + 1)
		&& phase != swd_pkg::SWD_TX_DATA && !timeout;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mem_req <= '0;
			busy    <= 1'b0;
			fw_req  <= '0;
			fw_cmd  <= 8'h00;
		end else begin
			fw_req.req <= 1'b0;
			if (mem_done) begin
				mem_req.req <= 1'b0;
				busy        <= 1'b0;
			end
			if (rx_done && nbits == 5'd15 && phase == swd_pkg::SWD_RX_ADDR && cmd[5]) begin
				mem_req.req     <= 1'b1; // [RULE13]
				mem_req.write   <= 1'b0;
				mem_req.dbg_map <= cmd[2]; // [RULE16]
				mem_req.word    <= cmd[3];
				mem_req.addr    <= cmd[3] ? {shreg[14:0], 1'b0} : {shreg[14:0], sync2}; // [RULE15]
				busy            <= 1'b1;
			end else if (rx_done && nbits == 5'd15 && phase == swd_pkg::SWD_RX_DATA
					&& cmd[7:6] == 2'b11) begin
				mem_req.req     <= 1'b1; // [RULE14]
				mem_req.write   <= 1'b1;
				mem_req.dbg_map <= cmd[2]; // [RULE16]
				mem_req.word    <= cmd[3];
				mem_req.addr    <= cmd[3] ? {addr[15:1], 1'b0} : addr; // [RULE15]
				mem_req.wdata   <= {shreg[14:0], sync2};
				busy            <= 1'b1;
			end
			if (rx_done && nbits == 5'd7 && phase == swd_pkg::SWD_RX_OPC
					&& background_debug_mode) begin // [RULE17]
				fw_cmd <= {shreg[6:0], sync2};
				// Opcode bit 5 marks a register read
				if (is_fw_rw({shreg[6:0], sync2}) && shreg[4]) begin
					fw_req.req     <= 1'b1; // [RULE18]
					fw_req.write   <= 1'b0;
					fw_req.reg_sel <= {shreg[1:0], sync2};
				end
			end else if (rx_done && nbits == 5'd15 && phase == swd_pkg::SWD_RX_DATA
					&& cmd[7:6] == 2'b01) begin
				fw_req.req     <= 1'b1; // [RULE18]
				fw_req.write   <= 1'b1;
				fw_req.reg_sel <= cmd[2:0];
				fw_req.wdata   <= {shreg[14:0], sync2};
			end
		end
	end
	assign tx_ready = (busy && mem_done && !mem_req.write) || fw_rdata_valid;

	// Free-cycle search and cycle steal
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wait_cnt <= 8'h00;
		end else if (!mem_req.req || cpu_bus_free) begin
			wait_cnt <= 8'h00;
		end else if (wait_cnt != 8'(STEAL_CYC)) begin
			wait_cnt <= wait_cnt + 8'h01;
		end
	end
	assign cpu_freeze = mem_req.req && !cpu_bus_free && wait_cnt == 8'(STEAL_CYC); // [RULE11]
	assign dbg_map_en = mem_req.req && mem_req.dbg_map; // [RULE16]

	// Background mode state and data-less commands
	logic op_strobe;
	logic [7:0] op_now;
	assign op_now    = {shreg[6:0], sync2};
	assign op_strobe = rx_done && nbits == 5'd7 && phase == swd_pkg::SWD_RX_OPC;

	// Marks the first clock after reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			boot_pending <= 1'b1;
		end else begin
			boot_pending <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			background_debug_mode <= 1'b0;
			bg_enter_req          <= 1'b0;
			bg_request_dropped    <= 1'b0;
			resume_req            <= 1'b0;
			single_step_cmd       <= 1'b0;
			tag_and_resume_cmd    <= 1'b0;
		end else begin
			bg_enter_req       <= 1'b0;
			bg_request_dropped <= 1'b0;
			resume_req         <= 1'b0;
			single_step_cmd    <= 1'b0;
			tag_and_resume_cmd <= 1'b0;
			// Only out of reset, so a later exit is not undone
			if (boot_pending && special_single_chip && debug_firmware_enable) begin
				background_debug_mode <= 1'b1; // [RULE1]
			end
			if (bdm_exit) begin
				background_debug_mode <= 1'b0;
			end
			if (op_strobe && op_now == `SWD_OP_BACKGROUND) begin
				if (debug_firmware_enable) begin
					bg_enter_req          <= 1'b1; // [RULE12]
					background_debug_mode <= 1'b1;
				end else begin
					bg_request_dropped <= 1'b1; // [RULE23]
				end
			end
			if (op_strobe && background_debug_mode) begin // [RULE17]
				resume_req         <= op_now == `SWD_OP_GO || op_now == `SWD_OP_TAG_AND_RESUME_CMD; // [RULE19]
				single_step_cmd    <= op_now == `SWD_OP_TRACE;
				tag_and_resume_cmd <= op_now == `SWD_OP_TAG_AND_RESUME_CMD;
			end
		end
	end
	// Debug registers FF00-FF06 and ROM FF20 up are visible while active
	assign dbg_rom_map_en = background_debug_mode; // [RULE2] [RULE17]
endmodule : swd_port

// >>> verif/swd_host.sv
`timescale 1ns/1ps
module swd_host (
	input wire logic clk,
	input wire logic debug_wire_pin_i,
	output logic     host_drv,
	output logic     host_oe
);
	initial begin
		host_drv = 1'b1;
		host_oe = 1'b0;
	end
	task automatic tx_bit(input logic b);
		@(posedge clk);
		host_oe <= 1'b1;
		host_drv <= 1'b0;
		repeat (b ? 4 : 14) @(posedge clk);
		host_drv <= 1'b1;
		repeat (b ? 11 : 1) @(posedge clk);
		host_oe <= 1'b0;
		repeat ($urandom % 3) @(posedge clk);
	endtask : tx_bit
	task automatic rx_bit(output logic b);
		@(posedge clk);
		host_oe <= 1'b1;
		host_drv <= 1'b0;
		repeat (3) @(posedge clk);
		host_oe <= 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		b = debug_wire_pin_i;
		repeat (9 + $urandom % 3) @(posedge clk);
	endtask : rx_bit
	task automatic tx8(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) tx_bit(v[i]);
	endtask : tx8
	task automatic tx16(input logic [15:0] v);
		for (int i = 15; i >= 0; i--) tx_bit(v[i]);
	endtask : tx16
	task automatic rx16(output logic [15:0] v);
		logic b;
		for (int i = 15; i >= 0; i--) begin
			rx_bit(b);
			v[i] = b;
		end
	endtask : rx16
endmodule : swd_host

// >>> verif/swd_port_sva.sv
`timescale 1ns/1ps
module swd_port_sva #(
	parameter int STEAL_CYC = 128
) (
	input wire logic                  clk,
	input wire logic                  resetn,
	input wire logic                  debug_wire_pin_i,
	input wire logic                  debug_wire_pin_oe,
	input wire logic                  cpu_bus_free,
	input wire logic                  cpu_freeze,
	input wire swd_pkg::swd_mem_req_s mem_req,
	input wire logic                  mem_done,
	input wire logic                  dbg_map_en,
	input wire logic                  dbg_rom_map_en,
	input wire logic                  background_debug_mode,
	input wire logic                  debug_firmware_enable,
	input wire logic                  bg_enter_req,
	input wire logic                  bg_request_dropped,
	input wire swd_pkg::swd_fw_req_s  fw_req,
	input wire logic                  timeout
);
	logic [9:0] idle;
	logic [8:0] wc;
	default clocking dc @(posedge clk); endclocking
	default disable iff (!resetn);
	// Cycles since the line was last low
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) idle <= '0;
		else if (!debug_wire_pin_i) idle <= '0;
		else if (idle != '1) idle <= idle + 10'h1;
	// Busy cycles met by a pending access
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) wc <= '0;
		else if (mem_req.req && !cpu_bus_free && !mem_done) wc <= wc + 9'h1;
		else wc <= '0;
	AST_ROM_MAP: assert property (dbg_rom_map_en == background_debug_mode)
		else $error("rom map differs from mode");
	AST_DBG_MAP: assert property (dbg_map_en == (mem_req.req && mem_req.dbg_map))
		else $error("debug map outside its access");
	AST_WORD_ALIGN: assert property (mem_req.req && mem_req.word |-> !mem_req.addr[0])
		else $error("unaligned word access");
	AST_REQ_HOLD: assert property (mem_req.req && !mem_done |=> mem_req.req && $stable(mem_req.addr))
		else $error("access dropped early");
	AST_STEAL: assert property (int'(wc) >= STEAL_CYC && mem_req.req && !cpu_bus_free
		|-> cpu_freeze)
		else $error("no cycle stolen");
	AST_FW_GATE: assert property (fw_req.req |-> background_debug_mode ##1 !fw_req.req)
		else $error("firmware request out of mode");
	AST_BG_GATE: assert property (bg_enter_req || bg_request_dropped |->
		bg_enter_req == $past(debug_firmware_enable)
		&& bg_request_dropped != $past(debug_firmware_enable))
		else $error("background entry ignores enable");
	AST_RX_QUIET: assert property ($fell(debug_wire_pin_i) && !debug_wire_pin_oe |=> !debug_wire_pin_oe)
		else $error("line driven at host edge");
	AST_TIMEOUT: assert property (timeout |-> idle > 10'h1E0)
		else $error("early timeout");
endmodule : swd_port_sva

// >>> verif/swd_port_tb.sv
`timescale 1ns/1ps
module swd_port_tb;
	logic clk, resetn, special_single_chip, debug_wire_pin_i, debug_wire_pin_o;
	logic debug_wire_pin_oe, cpu_bus_free, cpu_freeze, mem_done, dbg_map_en, dbg_rom_map_en;
	logic background_debug_mode, debug_firmware_enable, bdm_exit, bg_enter_req;
	logic bg_request_dropped, fw_rdata_valid, resume_req, single_step_cmd, tag_and_resume_cmd;
	logic timeout, host_drv, host_oe, free_mode;
	logic [15:0] mem_rdata, fw_rdata, rd_val, fw_val;
	logic [7:0] fw_cmd;
	logic [6:0] seen;
	swd_pkg::swd_mem_req_s mem_req, memo;
	swd_pkg::swd_fw_req_s fw_req, fwo;
	int fail_count, n_checks;
	logic [7:0] hw_ops [8] = '{8'hE4, 8'hEC, 8'hE0, 8'hE8, 8'hC4, 8'hCC, 8'hC0, 8'hC8};
	logic [7:0] fw_ops [12] = '{8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67,
		8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47};
	swd_port uut (.clk, .resetn, .special_single_chip, .debug_wire_pin_i, .debug_wire_pin_o,
		.debug_wire_pin_oe, .cpu_bus_free, .cpu_freeze, .mem_req, .mem_done, .mem_rdata,
		.dbg_map_en, .dbg_rom_map_en, .background_debug_mode, .debug_firmware_enable,
		.bdm_exit, .bg_enter_req, .bg_request_dropped, .fw_req, .fw_cmd, .fw_rdata_valid,
		.fw_rdata, .resume_req, .single_step_cmd, .tag_and_resume_cmd, .timeout);
	swd_host host (.clk, .debug_wire_pin_i, .host_drv, .host_oe);
	// Pulled-up line
	assign debug_wire_pin_i = host_oe ? host_drv : (debug_wire_pin_oe ? debug_wire_pin_o : 1'b1);
	initial clk = 1'b0;
	always #50 clk = ~clk;
	// Bus and firmware responders, sticky pulse flags
	always @(posedge clk) begin
		cpu_bus_free <= free_mode && ($urandom % 2 == 0);
		mem_done <= mem_req.req && !mem_done && (cpu_bus_free || cpu_freeze);
		mem_rdata <= rd_val;
		fw_rdata_valid <= fw_req.req && !fw_req.write;
		fw_rdata <= fw_val;
		seen <= seen | {bg_enter_req, bg_request_dropped, resume_req, single_step_cmd,
			tag_and_resume_cmd, cpu_freeze, timeout};
		if (mem_req.req) memo <= mem_req;
		if (fw_req.req) fwo <= fw_req;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	function automatic logic [19:0] exp_req(input logic [7:0] op, input logic [15:0] a);
		return {1'b1, ~op[5], op[2], op[3], a[15:1], a[0] & ~op[3]};
	endfunction : exp_req
	function automatic logic [6:0] exp_seen(input logic [7:0] op, input logic en);
		return {op == 8'h90 && en, op == 8'h90 && !en, op == 8'h08 || op == 8'h18, op == 8'h10,
			op == 8'h18, 2'h0};
	endfunction : exp_seen
	task automatic clr;
		@(negedge clk);
		seen = '0;
		memo = '0;
		fwo = '0;
	endtask : clr
	task automatic rst(input logic ssc, input logic en);
		resetn <= 1'b0;
		special_single_chip <= ssc;
		debug_firmware_enable <= en;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : rst
	task automatic hw(input logic [7:0] op);
		logic [15:0] a, d, r;
		a = 16'($urandom);
		d = 16'($urandom);
		rd_val = 16'($urandom);
		clr();
		host.tx8(op);
		host.tx16(a);
		if (op[5]) begin
			repeat (150) @(posedge clk);
			host.rx16(r);
			chk(32'(r), 32'(rd_val));
		end else begin
			host.tx16(d);
			repeat (150) @(posedge clk);
			chk(32'(memo.wdata), 32'(d));
		end
		chk({memo.req, memo.write, memo.dbg_map, memo.word, memo.addr}, exp_req(op, a));
	endtask : hw
	task automatic fw(input logic [7:0] op);
		logic [15:0] d, r;
		d = 16'($urandom);
		fw_val = 16'($urandom);
		clr();
		host.tx8(op);
		if (op[5]) begin
			repeat (32) @(posedge clk);
			host.rx16(r);
			chk(32'(r), 32'(fw_val));
		end else begin
			host.tx16(d);
			repeat (32) @(posedge clk);
			chk(32'(fwo.wdata), 32'(d));
		end
		chk({fwo.req, fwo.write, fwo.reg_sel, fw_cmd}, {1'b1, ~op[5], op[2:0], op});
	endtask : fw
	task automatic nd(input logic [7:0] op);
		clr();
		host.tx8(op);
		repeat (64) @(posedge clk);
		chk(32'(seen), 32'(exp_seen(op, debug_firmware_enable)));
	endtask : nd
	initial begin
		void'($urandom(32'h6a3c81fd));
		{resetn, special_single_chip, debug_firmware_enable, bdm_exit, free_mode} = '0;
		{cpu_bus_free, mem_done, fw_rdata_valid, mem_rdata, fw_rdata, rd_val, fw_val} = '0;
		rst(1'b0, 1'b0);
		chk(32'(background_debug_mode), 32'h0);
		free_mode = 1'b1;
		foreach (hw_ops[i]) hw(hw_ops[i]);
		free_mode = 1'b0;
		hw(8'hE0);
		chk(32'(seen[1]), 32'h1);
		free_mode = 1'b1;
		nd(8'h90);
		debug_firmware_enable <= 1'b1;
		nd(8'h90);
		clr();
		repeat (4) host.tx_bit(1'b1);
		repeat (600) @(posedge clk);
		chk(32'(seen[0]), 32'h1);
		hw(8'hC8);
		rst(1'b1, 1'b1);
		chk(32'(background_debug_mode), 32'h1);
		foreach (fw_ops[i]) fw(fw_ops[i]);
		nd(8'h10);
		nd(8'h18);
		nd(8'h08);
		@(posedge clk) bdm_exit <= 1'b1;
		@(posedge clk) bdm_exit <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(background_debug_mode), 32'h0);
		clr();
		host.tx8(8'h45);
		host.tx16(16'hA5A5);
		repeat (32) @(posedge clk);
		chk(32'(fwo.req), 32'h0);
		conclude();
	end
	// About two and a half times the expected run
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		conclude();
	end
endmodule : swd_port_tb
bind swd_port swd_port_sva #(.STEAL_CYC(STEAL_CYC)) chk_i (.clk, .resetn, .debug_wire_pin_i,
	.debug_wire_pin_oe, .cpu_bus_free, .cpu_freeze, .mem_req, .mem_done, .dbg_map_en,
	.dbg_rom_map_en, .background_debug_mode, .debug_firmware_enable, .bg_enter_req,
	.bg_request_dropped, .fw_req, .timeout);
